// ### verilog/phy_ctrl_pkg.sv
// constants and types for the basic mode control register block
package phy_ctrl_pkg;

    // ****************************************************************
    // register field positions and management addressing
    // ****************************************************************
    localparam int         BIT_SPEED   = 13;
    localparam int         BIT_AN_EN   = 12;
    localparam int         BIT_PDOWN   = 11;
    localparam int         BIT_ISO     = 10;
    localparam int         BIT_RESTART = 9;
    localparam int         BIT_DUPLEX  = 8;
    localparam logic [4:0] REG_BASIC_MODE_CONTROL = 5'h00;
    localparam logic [4:0] ISO_PHY_ADDR           = 5'h00;
    localparam logic [1:0] OP_READ                = 2'h2;
    localparam logic [1:0] OP_WRITE               = 2'h1;
    localparam logic [15:0] UNMAPPED_READ         = 16'h0000;

    // ****************************************************************
    // frame bit counts and startup timing
    // ****************************************************************
    localparam logic [5:0] PREAMBLE_LEN   = 6'h20;
    localparam logic [3:0] HDR_LAST       = 4'hC;
    localparam logic [3:0] TA_LAST        = 4'h1;
    localparam logic [3:0] DATA_LAST      = 4'hF;
    localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
    localparam logic [1:0] STRAP_DONE_CNT = 2'h3;

    // ****************************************************************
    // values after reset, before the strap pins are taken
    // ****************************************************************
    localparam logic RST_SPEED   = 1'h0;
    localparam logic RST_AN_EN   = 1'h0;
    localparam logic RST_PDOWN   = 1'h0;
    localparam logic RST_ISO     = 1'h0;
    localparam logic RST_RESTART = 1'h0;
    localparam logic RST_DUPLEX  = 1'h0;

    typedef enum logic [2:0] {
        MG_PREAMBLE,
        MG_HEADER,
        MG_TURN,
        MG_READ_DATA,
        MG_WRITE_DATA
    } mgmt_state_t;

endpackage : phy_ctrl_pkg

// ### verilog/phy_basic_control_upper_bits.sv
// basic mode control register upper bits behind serial management
`timescale 1ns/1ps
module phy_basic_control_upper_bits (
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESETN_I,
    input  wire logic       MDC_I,
    input  wire logic       MDIO_I,
    output logic            MDIO_O,
    output logic            MDIO_OEN_O,
    input  wire logic [4:0] PHY_ADDR_I,
    input  wire logic       NEGOTIATION_STRAP_LOW_I,
    input  wire logic       NEGOTIATION_STRAP_HIGH_I,
    input  wire logic [3:0] TXD_I,
    input  wire logic       TX_EN_I,
    input  wire logic       TX_ER_I,
    output logic      [3:0] CORE_TXD_O,
    output logic            CORE_TX_EN_O,
    output logic            CORE_TX_ER_O,
    input  wire logic       CORE_TX_CLK_I,
    input  wire logic       CORE_RX_CLK_I,
    input  wire logic [3:0] CORE_RXD_I,
    input  wire logic       CORE_RX_DV_I,
    input  wire logic       CORE_RX_ER_I,
    input  wire logic       CORE_COL_I,
    input  wire logic       CORE_CRS_I,
    output logic            TX_CLK_O,
    output logic            RX_CLK_O,
    output logic      [3:0] RXD_O,
    output logic            RX_DV_O,
    output logic            RX_ER_O,
    output logic            COL_O,
    output logic            CRS_O,
    output logic            MII_OEN_O,
    input  wire logic       AN_SPEED_100_I,
    input  wire logic       AN_FULL_DUPLEX_I,
    input  wire logic       AN_STARTED_I,
    output logic            AN_ENABLE_O,
    output logic            AN_RESTART_O,
    output logic            POWER_DOWN_O,
    output logic            LINK_SPEED_100_O,
    output logic            LINK_FULL_DUPLEX_O
);

    // ****************************************************************
    // reset release and pin synchronisers
    // ****************************************************************
    logic [1:0]  rst_ff;
    logic        rst_n;
    logic [14:0] pins_raw;
    logic [14:0] sync1;
    logic [14:0] sync2;
    logic        mdc_s;
    logic        mdio_s;
    logic [4:0]  phy_addr_s;
    logic        strap_low_s;
    logic        strap_high_s;
    logic [3:0]  txd_s;
    logic        tx_en_s;
    logic        tx_er_s;
    logic        mdc_prev;
    logic        mdc_rise;

    // two-stage release of the asynchronous reset
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) rst_ff <= 2'h0;
        else           rst_ff <= {rst_ff[0], 1'h1};
    end
    assign rst_n = rst_ff[1];

    assign pins_raw = {MDC_I, MDIO_I, PHY_ADDR_I, NEGOTIATION_STRAP_LOW_I,
                       NEGOTIATION_STRAP_HIGH_I, TXD_I, TX_EN_I, TX_ER_I};

    // two flip-flops per pin bit
    genvar gi;
    generate
        for (gi = 0; gi < 15; gi++) begin : g_sync
            always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
                if (!rst_n) begin
                    sync1[gi] <= 1'h0;
                    sync2[gi] <= 1'h0;
                end else begin
                    sync1[gi] <= pins_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    assign {mdc_s, mdio_s, phy_addr_s, strap_low_s, strap_high_s,
            txd_s, tx_en_s, tx_er_s} = sync2;

    // management clock edge detect on the synchronised copy
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) mdc_prev <= 1'h0;
        else        mdc_prev <= mdc_s;
    end
    assign mdc_rise = mdc_s & ~mdc_prev;

    // ****************************************************************
    // serial management frame engine
    // ****************************************************************
    phy_ctrl_pkg::mgmt_state_t state;
    logic [5:0]  pre_cnt;
    logic [3:0]  bit_cnt;
    logic [11:0] hdr;
    logic [12:0] hdr_full;
    logic        hdr_ok;
    logic        hdr_rd;
    logic        hdr_wr;
    logic        is_read;
    logic        reg_hit;
    logic [15:0] shift;
    logic        wr_stb;
    logic [15:0] wr_data;
    logic [15:0] reg_rd;

    assign hdr_full = {hdr, mdio_s};
    assign hdr_ok   = hdr_full[12] & (hdr_full[9:5] == phy_addr_s);
    assign hdr_rd   = hdr_ok & (hdr_full[11:10] == phy_ctrl_pkg::OP_READ);
    assign hdr_wr   = hdr_ok & (hdr_full[11:10] == phy_ctrl_pkg::OP_WRITE);

    // frame decode, read shift-out and write capture
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state      <= phy_ctrl_pkg::MG_PREAMBLE;
            pre_cnt    <= 6'h00;
            bit_cnt    <= 4'h0;
            hdr        <= 12'h000;
            is_read    <= 1'h0;
            reg_hit    <= 1'h0;
            shift      <= 16'h0000;
            wr_stb     <= 1'h0;
            wr_data    <= 16'h0000;
            MDIO_O     <= 1'h1;
            MDIO_OEN_O <= 1'h1;
        end else begin
            wr_stb <= 1'h0;
            if (mdc_rise) begin
                case (state)
                    phy_ctrl_pkg::MG_PREAMBLE: begin
                        if (mdio_s) begin
                            if (pre_cnt != phy_ctrl_pkg::PREAMBLE_LEN)
                                pre_cnt <= pre_cnt + 6'h01;
                        end else begin
                            if (pre_cnt == phy_ctrl_pkg::PREAMBLE_LEN)
                                state <= phy_ctrl_pkg::MG_HEADER;
                            pre_cnt <= 6'h00;
                            bit_cnt <= 4'h0;
                        end
                    end
                    phy_ctrl_pkg::MG_HEADER: begin
                        hdr     <= hdr_full[11:0];
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == phy_ctrl_pkg::HDR_LAST) begin
                            bit_cnt <= 4'h0;
                            is_read <= hdr_rd;
                            reg_hit <= hdr_full[4:0] ==
                                       phy_ctrl_pkg::REG_BASIC_MODE_CONTROL;
                            if (hdr_rd || hdr_wr)
                                state <= phy_ctrl_pkg::MG_TURN;
                            else
                                state <= phy_ctrl_pkg::MG_PREAMBLE;
                        end
                    end
                    phy_ctrl_pkg::MG_TURN: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (is_read && bit_cnt == 4'h0) begin
                            MDIO_O     <= 1'h0; // second turnaround bit
                            MDIO_OEN_O <= 1'h0;
                        end
                        if (bit_cnt == phy_ctrl_pkg::TA_LAST) begin
                            bit_cnt <= 4'h0;
                            if (is_read) begin
                                state  <= phy_ctrl_pkg::MG_READ_DATA;
                                MDIO_O <= reg_rd[15];
                                shift  <= {reg_rd[14:0], 1'h0};
                            end else begin
                                state <= phy_ctrl_pkg::MG_WRITE_DATA;
                            end
                        end
                    end
                    phy_ctrl_pkg::MG_READ_DATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        MDIO_O  <= shift[15];
                        shift   <= {shift[14:0], 1'h0};
                        if (bit_cnt == phy_ctrl_pkg::DATA_LAST) begin
                            MDIO_O     <= 1'h1;
                            MDIO_OEN_O <= 1'h1;
                            state      <= phy_ctrl_pkg::MG_PREAMBLE;
                        end
                    end
                    phy_ctrl_pkg::MG_WRITE_DATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        shift   <= {shift[14:0], mdio_s};
                        if (bit_cnt == phy_ctrl_pkg::DATA_LAST) begin
                            wr_stb  <= reg_hit;
                            wr_data <= {shift[14:0], mdio_s};
                            state   <= phy_ctrl_pkg::MG_PREAMBLE;
                        end
                    end
                    default: state <= phy_ctrl_pkg::MG_PREAMBLE;
                endcase
            end
        end
    end

    // ****************************************************************
    // control register bits and strap capture
    // ****************************************************************
    logic [1:0] strap_cnt;
    logic       strap_load;
    logic       speed;
    logic       an_en;
    logic       pdown;
    logic       iso;
    logic       restart;
    logic       duplex;
    logic       restart_set;

    assign strap_load  = (strap_cnt == phy_ctrl_pkg::STRAP_LOAD_CNT);
    assign restart_set = wr_stb & wr_data[phy_ctrl_pkg::BIT_RESTART] &
                         wr_data[phy_ctrl_pkg::BIT_AN_EN];
    // unused and reserved bits read as zero; other registers read zero
    assign reg_rd = reg_hit ? {2'h0, speed, an_en, pdown, iso, restart,
                               duplex, 8'h00}
                            : phy_ctrl_pkg::UNMAPPED_READ;

    // strap settle counter: load once synchronised pins are valid
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n)
            strap_cnt <= 2'h0;
        else if (strap_cnt != phy_ctrl_pkg::STRAP_DONE_CNT)
            strap_cnt <= strap_cnt + 2'h1;
    end

    // register bits: strap load, management writes, self-clear
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            speed   <= phy_ctrl_pkg::RST_SPEED;
            an_en   <= phy_ctrl_pkg::RST_AN_EN;
            pdown   <= phy_ctrl_pkg::RST_PDOWN;
            iso     <= phy_ctrl_pkg::RST_ISO;
            restart <= phy_ctrl_pkg::RST_RESTART;
            duplex  <= phy_ctrl_pkg::RST_DUPLEX;
        end else if (strap_load) begin
            an_en  <= strap_low_s & strap_high_s;
            speed  <= strap_low_s;
            duplex <= strap_high_s;
            iso    <= (phy_addr_s == phy_ctrl_pkg::ISO_PHY_ADDR);
        end else begin
            if (wr_stb) begin
                speed  <= wr_data[phy_ctrl_pkg::BIT_SPEED];
                an_en  <= wr_data[phy_ctrl_pkg::BIT_AN_EN];
                pdown  <= wr_data[phy_ctrl_pkg::BIT_PDOWN];
                iso    <= wr_data[phy_ctrl_pkg::BIT_ISO];
                duplex <= wr_data[phy_ctrl_pkg::BIT_DUPLEX];
            end
            // writing zero never clears; set beats self-clear
            if (restart_set)
                restart <= 1'h1;
            else if (AN_STARTED_I)
                restart <= 1'h0;
        end
    end

    // ****************************************************************
    // link selection, negotiation control and MII gating
    // ****************************************************************
    logic tx_block;
    assign tx_block = iso | pdown;

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            AN_ENABLE_O        <= 1'h0;
            AN_RESTART_O       <= 1'h0;
            POWER_DOWN_O       <= 1'h0;
            LINK_SPEED_100_O   <= 1'h0;
            LINK_FULL_DUPLEX_O <= 1'h0;
        end else begin
            AN_ENABLE_O        <= an_en;
            AN_RESTART_O       <= restart_set;
            POWER_DOWN_O       <= pdown;
            LINK_SPEED_100_O   <= an_en ? AN_SPEED_100_I : speed;
            LINK_FULL_DUPLEX_O <= an_en ? AN_FULL_DUPLEX_I : duplex;
        end
    end

    // transmit toward the core, blocked when isolated or powered down
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            CORE_TXD_O   <= 4'h0;
            CORE_TX_EN_O <= 1'h0;
            CORE_TX_ER_O <= 1'h0;
        end else begin
            CORE_TXD_O   <= tx_block ? 4'h0 : txd_s;
            CORE_TX_EN_O <= ~tx_block & tx_en_s;
            CORE_TX_ER_O <= ~tx_block & tx_er_s;
        end
    end

    // receive toward the MAC; data and status silent powered down, clocks always passed, released when isolated
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            TX_CLK_O  <= 1'h0;
            RX_CLK_O  <= 1'h0;
            RXD_O     <= 4'h0;
            RX_DV_O   <= 1'h0;
            RX_ER_O   <= 1'h0;
            COL_O     <= 1'h0;
            CRS_O     <= 1'h0;
            MII_OEN_O <= 1'h1;
        end else begin
            TX_CLK_O  <= CORE_TX_CLK_I;
            RX_CLK_O  <= CORE_RX_CLK_I;
            RXD_O     <= pdown ? 4'h0 : CORE_RXD_I;
            RX_DV_O   <= ~pdown & CORE_RX_DV_I;
            RX_ER_O   <= ~pdown & CORE_RX_ER_I;
            COL_O     <= ~pdown & CORE_COL_I;
            CRS_O     <= ~pdown & CORE_CRS_I;
            MII_OEN_O <= iso;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_restart_req;
        restart_set && !strap_load;
    endsequence
    sequence s_restart_seen;
        restart && AN_RESTART_O;
    endsequence

    AST_AN_IGNORES_MANUAL: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) an_en |=> LINK_SPEED_100_O ==
        $past(AN_SPEED_100_I) && LINK_FULL_DUPLEX_O == $past(AN_FULL_DUPLEX_I))
        else $error("negotiated link not followed");
    AST_FORCED_USES_MANUAL: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) !an_en |=> LINK_SPEED_100_O == $past(speed)
        && LINK_FULL_DUPLEX_O == $past(duplex))
        else $error("forced link does not follow manual bits");
    AST_STRAP_AN: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) strap_load |=>
        an_en == ($past(strap_low_s) & $past(strap_high_s)))
        else $error("negotiation enable not loaded from straps");
    AST_PDOWN_SILENT: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) pdown |=> !RX_DV_O && !CORE_TX_EN_O && !CRS_O)
        else $error("traffic while powered down");
    AST_PDOWN_RX_IGNORED: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) pdown && CORE_RX_DV_I |=> RXD_O == 4'h0)
        else $error("receive data passed while powered down");
    AST_ISO_TX_IGNORED: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) iso |=> CORE_TXD_O == 4'h0 && !CORE_TX_ER_O)
        else $error("transmit inputs used while isolated");
    AST_ISO_RELEASE: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) iso |=> MII_OEN_O)
        else $error("MII outputs driven while isolated");
    AST_MGMT_WHILE_ISO: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) iso && wr_stb && !strap_load |=>
        iso == $past(wr_data[phy_ctrl_pkg::BIT_ISO]))
        else $error("management write lost while isolated");
    AST_ISO_ADDR_ZERO: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) strap_load |=> iso == ($past(phy_addr_s) == 5'h00))
        else $error("isolate default wrong for address");
    AST_RESTART_LAUNCH: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) s_restart_req |=> s_restart_seen)
        else $error("restart write did not launch negotiation");
    AST_RESTART_HOLD: assert property (@(posedge CORE_CLK_I)
        disable iff (!rst_n) restart && !AN_STARTED_I && !strap_load
        |=> restart[*2] or (restart ##1 $past(AN_STARTED_I)))
        else $error("restart bit cleared before negotiation began");

endmodule : phy_basic_control_upper_bits

// ### verif/mdio_station.sv
// management station model driving the serial management pins
`timescale 1ns/1ps
module mdio_station (
    input  wire logic clk_i,
    input  wire logic dev_mdio_i,
    input  wire logic dev_oen_n_i,
    output logic      mdc_o,
    output logic      mdio_o
);
    logic st_drive;
    logic st_bit;

    // shared line with a pull-up: released by both parties it reads one
    assign mdio_o = (st_drive ? st_bit : 1'b1)
                  & (dev_oen_n_i ? 1'b1 : dev_mdio_i);

    // clock stands low outside frames
    initial begin
        mdc_o = 1'b0;
        st_drive = 1'b0;
        st_bit = 1'b1;
    end

    // one bit time: data set with clock low, line sampled before the rise
    task automatic bit_cycle(input logic drv, input logic b,
                             output logic seen);
        mdc_o = 1'b0;
        st_drive = drv;
        st_bit = b;
        repeat (4) @(posedge clk_i);
        #1 seen = mdio_o;
        mdc_o = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : bit_cycle

    // whole frame, fresh preamble each time, register word msb first
    task automatic frame(input logic rd, input logic [4:0] phy,
                         input logic [4:0] regn, input logic [15:0] wd,
                         output logic [15:0] rd_data);
        logic [31:0] w;
        logic        s;
        int          i;
        w = {2'b01, rd ? phy_ctrl_pkg::OP_READ : phy_ctrl_pkg::OP_WRITE,
             phy, regn, 2'b10, wd};
        for (i = 0; i < 32; i++) begin
            bit_cycle(1'b1, 1'b1, s);
        end
        for (i = 0; i < 32; i++) begin
            bit_cycle(!(rd && i >= 14), w[31-i], s);
            if (i >= 16) begin
                rd_data[31-i] = s;
            end
        end
        bit_cycle(1'b0, 1'b1, s);
        mdc_o = 1'b0;
    endtask : frame
endmodule : mdio_station

// ### verif/phy_basic_control_upper_bits_tb_top.sv
// self-checking bench for the basic mode control upper bits
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module phy_basic_control_upper_bits_tb_top;
    logic        clk, rst_n, s_lo, s_hi, an_spd, an_dup, an_go;
    logic [4:0]  phy;
    logic [15:0] mii, rdv, d;
    logic        mdc, mdio, mdio_dev, mdio_oen, tx_en_o, rx_dv_o, tx_clk_o;
    logic        mii_oen, an_en_o, rs_o, pd_o, spd_o, dup_o;
    logic [3:0]  rxd_o, txd_o;
    logic        tx_er_o, rx_clk_o, rx_er_o, col_o, crs_o;
    int          seed, fails, checked, cycles, rcount, i;
    logic [15:0] corner [5] = '{16'h2100, 16'h0000, 16'h0400, 16'h0800,
                                16'h1000};
    localparam logic [4:0] REG0 = phy_ctrl_pkg::REG_BASIC_MODE_CONTROL;

    phy_basic_control_upper_bits u_dut (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .MDC_I(mdc), .MDIO_I(mdio),
        .MDIO_O(mdio_dev), .MDIO_OEN_O(mdio_oen), .PHY_ADDR_I(phy),
        .NEGOTIATION_STRAP_LOW_I(s_lo), .NEGOTIATION_STRAP_HIGH_I(s_hi),
        .TXD_I(mii[3:0]), .TX_EN_I(mii[4]), .TX_ER_I(mii[5]),
        .CORE_TXD_O(txd_o), .CORE_TX_EN_O(tx_en_o), .CORE_TX_ER_O(tx_er_o),
        .CORE_TX_CLK_I(mii[6]), .CORE_RX_CLK_I(mii[7]),
        .CORE_RXD_I(mii[11:8]), .CORE_RX_DV_I(mii[12]),
        .CORE_RX_ER_I(mii[13]), .CORE_COL_I(mii[14]), .CORE_CRS_I(mii[15]),
        .TX_CLK_O(tx_clk_o), .RX_CLK_O(rx_clk_o), .RXD_O(rxd_o),
        .RX_DV_O(rx_dv_o), .RX_ER_O(rx_er_o), .COL_O(col_o),
        .CRS_O(crs_o), .MII_OEN_O(mii_oen),
        .AN_SPEED_100_I(an_spd), .AN_FULL_DUPLEX_I(an_dup),
        .AN_STARTED_I(an_go), .AN_ENABLE_O(an_en_o), .AN_RESTART_O(rs_o),
        .POWER_DOWN_O(pd_o), .LINK_SPEED_100_O(spd_o),
        .LINK_FULL_DUPLEX_O(dup_o));

    mdio_station u_sta (.clk_i(clk), .dev_mdio_i(mdio_dev),
        .dev_oen_n_i(mdio_oen), .mdc_o(mdc), .mdio_o(mdio));

    // clock, timeout and restart pulse counting
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (rs_o === 1'b1) rcount++;
        if (cycles == 40000) begin
            fails++;
            report_and_stop();
        end
    end

    // readable bits of the word except restart (bit 9), all others read zero
    function automatic logic [15:0] fold(input logic [15:0] w);
        return w & 16'h3D00;
    endfunction : fold

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [4:0] r, input logic [15:0] v);
        logic [15:0] nul;
        u_sta.frame(1'b0, phy, r, v, nul);
    endtask : wr

    task automatic rd(input logic [4:0] r, output logic [15:0] v);
        u_sta.frame(1'b1, phy, r, 16'h0000, v);
    endtask : rd

    // reset with fresh strap values held well past release
    task automatic do_reset(input logic [4:0] a);
        phy = a;
        s_lo = 1'($random(seed));
        s_hi = 1'($random(seed));
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (12) @(posedge clk);
        #1;
    endtask : do_reset

    initial begin
        seed = 29537;
        {fails, checked, cycles, rcount} = '0;
        {rst_n, mii, an_spd, an_dup, an_go, s_lo, s_hi, phy} = '0;
        do_reset(5'h00);
        rd(REG0, rdv);
        `CHK("reset word", {2'b00, s_lo, s_lo & s_hi, 2'b01, 1'b0, s_hi,
             8'h00}, rdv)
        `CHK("isolated at reset", 1'b1, mii_oen)
        do_reset(5'($random(seed)) | 5'h01);
        rd(REG0, rdv);
        `CHK("reset word", {2'b00, s_lo, s_lo & s_hi, 2'b00, 1'b0, s_hi,
             8'h00}, rdv)
        // corner words first, then random ones; restart bit kept clear
        for (i = 0; i < 13; i++) begin
            d = (i < 5) ? corner[i] : 16'($random(seed)) & 16'hFDFF;
            wr(REG0, d);
            rd(REG0, rdv);
            `CHK("read back", fold(d), rdv)
            mii = 16'($random(seed));
            an_spd = 1'($random(seed));
            an_dup = 1'($random(seed));
            repeat (4) @(posedge clk);
            #1;
            `CHK("speed", d[12] ? an_spd : d[13], spd_o)
            `CHK("duplex", d[12] ? an_dup : d[8], dup_o)
            `CHK("an enable", d[12], an_en_o)
            `CHK("power down", d[11], pd_o)
            `CHK("mii enable", d[10], mii_oen)
            `CHK("tx enable", mii[4] & ~d[10] & ~d[11], tx_en_o)
            `CHK("rx data", d[11] ? 4'h0 : mii[11:8], rxd_o)
            `CHK("rx valid", mii[12] & ~d[11], rx_dv_o)
            `CHK("tx clock", mii[6], tx_clk_o)
            `CHK("tx word", (d[10] | d[11]) ? 5'h00 : {mii[5], mii[3:0]},
                 {tx_er_o, txd_o})
            `CHK("rx status", {mii[7], d[11] ? 3'h0 : mii[15:13]},
                 {rx_clk_o, crs_o, col_o, rx_er_o})
        end
        // restart: pending until started, zero write has no effect
        rcount = 0;
        wr(REG0, 16'h1200);
        rd(REG0, rdv);
        `CHK("restart pending", 16'h1200, rdv)
        `CHK("restart pulses", 1, rcount)
        wr(REG0, 16'h1000);
        rd(REG0, rdv);
        `CHK("restart kept", 16'h1200, rdv)
        an_go = 1'b1;
        @(posedge clk);
        #1 an_go = 1'b0;
        rd(REG0, rdv);
        `CHK("restart cleared", 16'h1000, rdv)
        // other register addresses read zero and ignore writes
        rd(5'h01, rdv);
        `CHK("unmapped read", phy_ctrl_pkg::UNMAPPED_READ, rdv)
        wr(5'h01, 16'hFFFF);
        rd(REG0, rdv);
        `CHK("unmapped write", 16'h1000, rdv)
        // a frame for another PHY address is dropped
        u_sta.frame(1'b0, phy ^ 5'h01, REG0, 16'h0000, rdv);
        rd(REG0, rdv);
        `CHK("foreign address", 16'h1000, rdv)
        report_and_stop();
    end
endmodule : phy_basic_control_upper_bits_tb_top
